// ===== sfram_master_model.sv
/*
 * sfram_master_model: behavioural serial bus master for the ram front end.
 * assumes callers enter its tasks just after a falling clock edge.
 */
`timescale 1ns/1ns
module sfram_master_model (
   input  wire logic clock,
   input  wire logic so,
   input  wire logic so_oe_n,
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n
);
   localparam int HALF = 6; // 24 ns, 48 ns serial period, just over the 20 MHz top rate
   logic mode3 = 1'b0;
   logic last = 1'b0;
   logic drove = 1'b0;
   logic oe_in_pause = 1'b0;
   logic miso;

   initial begin
      sck    = 1'b0;
      cs_n   = 1'b1;
      si     = 1'b0;
      hold_n = 1'b1;
   end

   always @(posedge clock) begin
      if (!so_oe_n) begin
         last  = so;
         drove = 1'b1;
      end
   end
   // a released line shows the inverse so stale data never reads as good
   assign miso = so_oe_n ? ~last : so;

   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask : wait_n

   task automatic select();
      sck   = mode3;
      drove = 1'b0;
      wait_n(HALF);
      cs_n  = 1'b0;
      wait_n(HALF);
   endtask : select

   task automatic xfer(input logic [7:0] tx, input int stop, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si  = tx[i];
         wait_n(HALF);
         if (i == stop) begin
            hold_n = 1'b0;
            wait_n(HALF);
            sck  = 1'b1;
            cs_n = 1'b1;
            wait_n(HALF);
            oe_in_pause = so_oe_n;
            sck  = 1'b0;
            cs_n = 1'b0;
            wait_n(HALF);
            hold_n = 1'b1;
            wait_n(2 * HALF);
         end
         sck   = 1'b1;
         rx[i] = miso;
         wait_n(HALF / 2);
         si    = ~si; // level away from the rising edge must not count
         wait_n(HALF - HALF / 2);
      end
   endtask : xfer

   task automatic deselect();
      if (!mode3) sck = 1'b0;
      wait_n(HALF);
      cs_n = 1'b1; // no wait for ready afterwards
      wait_n(HALF);
   endtask : deselect
endmodule : sfram_master_model

// ===== sfram_pkg.sv
/*
 * sfram_pkg: constants, command codes, status layout and state encoding
 * for the serial nonvolatile ram pin front end.
 * assumes one system clock of 250 MHz that oversamples every pin.
 */
package sfram_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS    = 4;
   localparam int SCK_MAX_MHZ      = 20;
   localparam int SCK_MIN_PER_NS   = 1000 / SCK_MAX_MHZ;
   // least half period of the serial clock, rounded up to whole cycles
   localparam int SCK_MIN_HALF_CYC = (SCK_MIN_PER_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES      = 2;

   // ************************************************************
   // array geometry
   // ************************************************************
   localparam int ADDR_W     = 13;
   localparam int DATA_W     = 8;
   localparam int MEM_DEPTH  = 8192;
   localparam int BIT_CNT_W  = 3;
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
   localparam logic [BIT_CNT_W-1:0] BIT_RST  = 3'h0;
   localparam logic [ADDR_W-1:0]    ADDR_RST = 13'h0000;
   localparam logic [ADDR_W-1:0]    ADDR_ONE = 13'h0001;

   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] CMD_WR_ENABLE  = 8'h06;
   localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
   localparam logic [7:0] CMD_RD_STATUS  = 8'h05;
   localparam logic [7:0] CMD_WR_STATUS  = 8'h01;
   localparam logic [7:0] CMD_RD_MEM     = 8'h03;
   localparam logic [7:0] CMD_WR_MEM     = 8'h02;

   // ************************************************************
   // status layout and reset values
   // ************************************************************
   localparam int STAT_PROT_EN_BIT = 7;
   localparam int STAT_BP_HI_BIT   = 3;
   localparam int STAT_BP_LO_BIT   = 2;
   localparam int STAT_WEL_BIT     = 1;
   localparam logic [7:0] STAT_WR_MASK = 8'h8c;
   localparam logic [7:0] STAT_RST     = 8'h00;
   localparam logic [7:0] BYTE_RST     = 8'h00;

   // protected ranges start at these addresses (upper quarter, upper half, all)
   localparam logic [ADDR_W-1:0] PROT_QUARTER = 13'h1800;
   localparam logic [ADDR_W-1:0] PROT_HALF    = 13'h1000;
   localparam logic [ADDR_W-1:0] PROT_ALL     = 13'h0000;

   typedef enum logic [6:0] {
      ST_OPCODE = 7'h01,
      ST_ADDR   = 7'h02,
      ST_WR_MEM = 7'h04,
      ST_RD_MEM = 7'h08,
      ST_WR_STS = 7'h10,
      ST_RD_STS = 7'h20,
      ST_IGNORE = 7'h40
   } sfram_state_t;

endpackage : sfram_pkg

// ===== sfram_slave.sv
/*
 * sfram_slave: serial peripheral slave front end of an 8192 x 8 byte
 * nonvolatile ram, with the array, status byte and write protection.
 * assumes the master clock, select, data, pause and protect pins are
 * asynchronous; all are oversampled by the 250 MHz clock.
 */
`timescale 1ns/1ns
module sfram_slave
   import sfram_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic si,
   input  wire logic hold_n,
   input  wire logic wp_n,
   output logic      so,
   output logic      so_oe_n
);
   import sfram_pkg::*;

   // ************************************************************
   // pin synchronisation and edge finding
   // ************************************************************
   logic [4:0]       pins_s;
   logic             sck_s;
   logic             cs_n_s;
   logic             si_s;
   logic             hold_n_s;
   logic             wp_n_s;
   logic             sck_d;
   logic             active;
   logic             sck_rise;
   logic             sck_fall;

   sfram_sync #(.WIDTH(5)) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .rst_val  (5'h1e),
      .async_in ({wp_n, hold_n, cs_n, si, sck}),
      .sync_out (pins_s)
   );

   assign sck_s    = pins_s[0];
   assign si_s     = pins_s[1];
   assign cs_n_s   = pins_s[2];
   assign hold_n_s = pins_s[3];
   assign wp_n_s   = pins_s[4];

   // edge history runs always so a mode 3 select never sees a stale edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sck_d <= 1'b0;
      end else begin
         sck_d <= sck_s;
      end
   end

   // pause masks both clock edges and select; the counters simply freeze
   assign active   = !cs_n_s && hold_n_s;
   assign sck_rise = active && sck_s && !sck_d;
   assign sck_fall = active && !sck_s && sck_d;

   // ************************************************************
   // array, status and protection
   // ************************************************************
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [7:0]        status;
   logic              wel;
   logic              wel_drop;
   logic              addr_prot;
   logic              sts_locked;
   logic [ADDR_W-1:0] addr;

   always_comb begin
      case (status[STAT_BP_HI_BIT:STAT_BP_LO_BIT])
         2'h1:    addr_prot = (addr >= PROT_QUARTER);
         2'h2:    addr_prot = (addr >= PROT_HALF);
         2'h3:    addr_prot = (addr >= PROT_ALL);
         default: addr_prot = 1'b0;
      endcase
   end

   assign sts_locked = status[STAT_PROT_EN_BIT] && !wp_n_s;

   // ************************************************************
   // serial receive and command sequencing
   // ************************************************************
   sfram_state_t         state;
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic [7:0]           shift_in;
   logic [7:0]           next_byte;
   logic                 addr_second;
   logic                 cmd_read;
   logic [7:0]           tx;
   logic                 byte_done;

   assign next_byte = {shift_in[6:0], si_s};
   assign byte_done = sck_rise && (bit_cnt == BIT_LAST);

   // select high outside a pause resets the sequence, so each selection starts at an opcode
   always_ff @(posedge clock) begin
      if (!rst_n || (cs_n_s && hold_n_s)) begin
         state       <= ST_OPCODE;
         bit_cnt     <= BIT_RST;
         shift_in    <= BYTE_RST;
         addr_second <= 1'b0;
         cmd_read    <= 1'b0;
      end else if (sck_rise) begin
         bit_cnt  <= bit_cnt + 3'h1;
         shift_in <= next_byte;
         if (bit_cnt == BIT_LAST) begin
            case (state)
               ST_OPCODE: begin
                  case (next_byte)
                     CMD_RD_STATUS: state <= ST_RD_STS;
                     CMD_WR_STATUS: state <= ST_WR_STS;
                     CMD_RD_MEM: begin
                        state    <= ST_ADDR;
                        cmd_read <= 1'b1;
                     end
                     CMD_WR_MEM: begin
                        state    <= ST_ADDR;
                        cmd_read <= 1'b0;
                     end
                     CMD_WR_ENABLE:  state <= ST_IGNORE;
                     CMD_WR_DISABLE: state <= ST_IGNORE;
                     default:        state <= ST_IGNORE;
                  endcase
               end
               ST_ADDR: begin
                  addr_second <= 1'b1;
                  if (addr_second) begin
                     state <= cmd_read ? ST_RD_MEM : ST_WR_MEM;
                  end
               end
               ST_WR_STS: state <= ST_IGNORE;
               ST_RD_MEM: state <= ST_RD_MEM;
               ST_WR_MEM: state <= ST_WR_MEM;
               ST_RD_STS: state <= ST_RD_STS;
               ST_IGNORE: state <= ST_IGNORE;
               default:   state <= ST_IGNORE;
            endcase
         end
      end
   end

   // address: high byte keeps only its low five bits, then auto-increment
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         addr <= ADDR_RST;
      end else if (byte_done) begin
         if (state == ST_ADDR && !addr_second) begin
            addr <= {next_byte[4:0], addr[7:0]};
         end else if (state == ST_ADDR) begin
            addr <= {addr[12:8], next_byte};
         end else if (state == ST_WR_MEM || state == ST_RD_MEM) begin
            addr <= addr + ADDR_ONE;
         end
      end
   end

   // array write lands on the last bit's edge, no busy period follows
   always_ff @(posedge clock) begin
      if (byte_done && state == ST_WR_MEM && wel && !addr_prot) begin
         mem[addr] <= next_byte;
      end
   end

   // status byte; enable latch falls once a write-type selection closes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status <= STAT_RST;
      end else if (byte_done && state == ST_WR_STS && wel && !sts_locked) begin
         status <= next_byte & STAT_WR_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wel      <= 1'b0;
         wel_drop <= 1'b0;
      end else if (cs_n_s && hold_n_s) begin
         wel_drop <= 1'b0;
         if (wel_drop) begin
            wel <= 1'b0;
         end
      end else if (byte_done && state == ST_OPCODE) begin
         if (next_byte == CMD_WR_ENABLE) begin
            wel <= 1'b1;
         end else if (next_byte == CMD_WR_DISABLE) begin
            wel <= 1'b0;
         end else if (next_byte == CMD_WR_MEM || next_byte == CMD_WR_STATUS) begin
            wel_drop <= 1'b1;
         end
      end
   end

   // ************************************************************
   // serial transmit
   // ************************************************************
   logic drive;
   logic rd_state;

   assign rd_state = (state == ST_RD_MEM) || (state == ST_RD_STS);

   // tx is reloaded at each byte boundary ahead of read data so the next falling edge has the msb
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx <= BYTE_RST;
      end else if (byte_done && state == ST_OPCODE && next_byte == CMD_RD_STATUS) begin
         tx <= {status[7:2], wel, 1'b0};
      end else if (byte_done && state == ST_RD_STS) begin
         tx <= {status[7:2], wel, 1'b0};
      end else if (byte_done && state == ST_ADDR && addr_second) begin
         tx <= mem[{addr[12:8], next_byte}];
      end else if (byte_done && state == ST_RD_MEM) begin
         tx <= mem[addr + ADDR_ONE];
      end else if (sck_fall && rd_state) begin
         tx <= {tx[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         so    <= 1'b0;
         drive <= 1'b0;
      end else if (cs_n_s && hold_n_s) begin
         drive <= 1'b0;
      end else if (sck_fall && rd_state) begin
         so    <= tx[7];
         drive <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         so_oe_n <= 1'b1;
      end else begin
         so_oe_n <= !(drive && !cs_n_s && hold_n_s);
      end
   end

endmodule : sfram_slave

// ===== sfram_slave_props.sv
/*
 * sfram_slave_props: pin-level checks on the serial ram front end.
 * assumes only the ports of sfram_slave; bound to it at the foot.
 */
`timescale 1ns/1ns
module sfram_slave_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so,
   input wire logic so_oe_n
);
   // ****************************************
   // output pin behaviour
   // ****************************************
   // six cycles cover the pin synchroniser plus the output register
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> so_oe_n && so == 1'b0)
      else $error("output driven after reset");
   a_idle_released: assert property ((cs_n && hold_n) [*6] |-> so_oe_n)
      else $error("output driven while deselected");
   a_hold_released: assert property ((!hold_n) [*6] |-> so_oe_n)
      else $error("output driven during pause");
   a_out_on_fall: assert property ($changed(so) && !so_oe_n |-> !sck)
      else $error("output changed while serial clock high");
   a_out_steady: assert property (sck [*2] ##0 !so_oe_n |-> $stable(so))
      else $error("output moved during high clock phase");
   a_drive_needs_sel: assert property ($fell(so_oe_n) |-> !cs_n && hold_n)
      else $error("drive began without select");
   a_drive_low_sck: assert property ($fell(so_oe_n) |-> !sck)
      else $error("drive began on high clock");
   a_drive_holds: assert property (!so_oe_n && !cs_n && hold_n |=> !so_oe_n)
      else $error("drive dropped mid read");
endmodule : sfram_slave_props

bind sfram_slave sfram_slave_props sfram_slave_props_i (.clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
   .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));

// ===== sfram_sync.sv
/*
 * sfram_sync: two flip-flop synchroniser for a group of pin inputs.
 * assumes the inputs are asynchronous to clock; first stage is read by
 * the second stage only.
 */
`timescale 1ns/1ns
module sfram_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] rst_val,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // ************************************************************
   // per-bit two stage chain
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clock) begin
            // reset to the pin's idle level so no false select or pause follows reset
            if (!rst_n) begin
               meta[g]     <= rst_val[g];
               sync_out[g] <= rst_val[g];
            end else begin
               meta[g]     <= async_in[g];
               sync_out[g] <= meta[g];
            end
         end
      end
   endgenerate

endmodule : sfram_sync

// ===== testbench.sv
/*
 * testbench: drives the serial ram front end through the master model.
 * assumes the design package and the checker are compiled first.
 */
`timescale 1ns/1ns
module testbench;
   import sfram_pkg::*;
   localparam int         LIMIT = 40000;
   localparam logic [7:0] NUL   = 8'h00;
   logic       clock;
   logic       rst_n;
   logic       wp_n;
   logic       sck, cs_n, si, hold_n, so, so_oe_n;
   int         err_total;
   int         n_checks;
   int         cycles = 0;
   logic [7:0] rxb [5];

   always #2 clock = ~clock;

   sfram_slave sfram_slave_i (.clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
      .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));
   sfram_master_model sfram_master_model_i (.clock(clock), .so(so), .so_oe_n(so_oe_n), .sck(sck),
      .cs_n(cs_n), .si(si), .hold_n(hold_n));

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         results();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic frame(input int n, input logic [7:0] b0, b1, b2, b3, b4, input int stop = -1);
      logic [7:0] tx [5];
      tx = '{b0, b1, b2, b3, b4};
      sfram_master_model_i.select();
      for (int k = 0; k < n; k++) sfram_master_model_i.xfer(tx[k], (k == n - 1) ? stop : -1, rxb[k]);
      sfram_master_model_i.deselect();
   endtask : frame

   task automatic wr(input logic [7:0] hi, lo, d);
      frame(1, CMD_WR_ENABLE, NUL, NUL, NUL, NUL);
      frame(4, CMD_WR_MEM, hi, lo, d, NUL);
   endtask : wr

   task automatic wrsr(input logic [7:0] v);
      frame(1, CMD_WR_ENABLE, NUL, NUL, NUL, NUL);
      frame(2, CMD_WR_STATUS, v, NUL, NUL, NUL);
   endtask : wrsr

   task automatic rd(input logic [7:0] hi, lo, exp);
      frame(4, CMD_RD_MEM, hi, lo, NUL, NUL);
      check(rxb[3], exp);
   endtask : rd

   task automatic rdsr(input logic [7:0] exp);
      // enable latch bit masked: its state after a refused status write is left open
      frame(2, CMD_RD_STATUS, NUL, NUL, NUL, NUL);
      check(rxb[1] & 8'hfd, exp);
   endtask : rdsr

   task automatic t_mem;
      sfram_master_model_i.mode3 = 1'b0;
      wr(8'hff, 8'hfe, 8'h5a);
      frame(1, CMD_WR_ENABLE, NUL, NUL, NUL, NUL);
      frame(5, CMD_WR_MEM, 8'hff, 8'hff, 8'ha5, 8'h3c);
      sfram_master_model_i.mode3 = 1'b1;
      frame(5, CMD_RD_MEM, 8'h1f, 8'hfe, NUL, NUL);
      check(rxb[3], 8'h5a);
      check(rxb[4], 8'ha5);
      rd(8'he0, 8'h00, 8'h3c);
      $display("test mem done");
   endtask : t_mem

   task automatic t_hold;
      sfram_master_model_i.mode3 = 1'b0;
      frame(4, CMD_RD_MEM, 8'h1f, 8'hff, NUL, NUL, 4);
      check(rxb[3], 8'ha5);
      check({7'h00, sfram_master_model_i.oe_in_pause}, 8'h01);
      $display("test hold done");
   endtask : t_hold

   task automatic t_protect;
      wr(8'h00, 8'h10, 8'h11);
      wr(8'h17, 8'hff, NUL);
      for (int bp = 1; bp < 4; bp++) begin
         wrsr(8'(bp << 2));
         wr(8'h17, 8'hff, 8'(bp));
      end
      rd(8'h17, 8'hff, 8'h01);
      rdsr(8'h0c);
      wr(8'h00, 8'h10, 8'h77);
      rd(8'h00, 8'h10, 8'h11);
      wrsr(8'h8c);
      wp_n = 1'b0;
      wrsr(NUL);
      rdsr(8'h8c);
      wp_n = 1'b1;
      wrsr(NUL);
      rdsr(NUL);
      frame(1, CMD_WR_ENABLE, NUL, NUL, NUL, NUL);
      frame(1, CMD_WR_DISABLE, NUL, NUL, NUL, NUL);
      frame(4, CMD_WR_MEM, 8'h00, 8'h10, 8'h99, NUL);
      rd(8'h00, 8'h10, 8'h11);
      $display("test protect done");
   endtask : t_protect

   task automatic t_badop;
      frame(4, 8'hff, CMD_RD_MEM, 8'h1f, 8'hff, NUL);
      check({7'h00, sfram_master_model_i.drove}, NUL);
      rd(8'h1f, 8'hff, 8'ha5);
      $display("test bad opcode done");
   endtask : t_badop

   initial begin
      clock     = 1'b0;
      rst_n     = 1'b0;
      wp_n      = 1'b1;
      err_total = 0;
      n_checks  = 0;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      t_mem();
      t_hold();
      t_protect();
      t_badop();
      results();
   end
endmodule : testbench
